// ### emrf_consts.vh
`ifndef EMRF_CONSTS_VH
`define EMRF_CONSTS_VH
// Register byte offsets on APB
`define EMRF_OFF_CTRL       12'h000
`define EMRF_OFF_PERIOD     12'h004
`define EMRF_OFF_COUNTER    12'h008
`define EMRF_OFF_INIT       12'h00c
`define EMRF_OFF_STATUS     12'h010
// Control register fields
`define EMRF_CTRL_REF_ON    0
`define EMRF_CTRL_WID_LO    1
`define EMRF_CTRL_WID_HI    2
// Reset values
`define EMRF_PERIOD_RST     12'h080
`define EMRF_CTRL_RST       3'h0
// Memory width codes
`define EMRF_WID32          2'h0
`define EMRF_WID16          2'h1
`define EMRF_WID8           2'h2
// Pending requests that force an urgent refresh
`define EMRF_URGENT_CNT     2'h3
`endif

// ### emrf_refresh.v
`include "emrf_consts.vh"
module emrf_refresh (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // Control
   input  wire        refreshEnable,
   input  wire [11:0] period,
   input  wire        sdramBusy,
   // Status
   output reg  [11:0] counter,
   output reg  [1:0]  pendingCount,
   output reg         refreshCmd,
   output reg         urgent
);
   wire expiry = refreshEnable && (counter == 12'h000);
   wire [1:0] pendPlus = pendingCount + 2'h1;

   always @(posedge clk_sys) begin
      if (srst) begin
         counter      <= `EMRF_PERIOD_RST;
         pendingCount <= 2'h0;
         refreshCmd   <= 1'b0;
         urgent       <= 1'b0;
      end else begin
         refreshCmd <= 1'b0;
         urgent     <= 1'b0;
         if (!refreshEnable) begin
            // Stay primed so counting resumes from the period
            counter <= period; // R1
         end else if (expiry) begin
            counter <= period; // R3
         end else begin
            counter <= counter - 12'h001; // R2
         end
         if (refreshEnable) begin
            if (expiry && !sdramBusy) begin
               refreshCmd   <= 1'b1; // R4
               pendingCount <= 2'h0; // R20
            end else if (expiry && pendPlus == `EMRF_URGENT_CNT) begin
               // Urgent overrides the access in progress
               refreshCmd   <= 1'b1; // R5
               urgent       <= 1'b1;
               pendingCount <= 2'h0; // R20
            end else if (expiry) begin
               pendingCount <= pendPlus; // R5
            end else if (!sdramBusy && pendingCount != 2'h0) begin
               refreshCmd   <= 1'b1;
               pendingCount <= 2'h0; // R20
            end
         end
      end
   end
endmodule

// ### emrf_packer.v
`include "emrf_consts.vh"
module emrf_packer (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // Control
   input  wire        start,
   input  wire [1:0]  width,
   input  wire [1:0]  beat,
   input  wire [31:0] memData,
   input  wire        capture,
   // Result
   output reg  [31:0] packWord
);
   always @(posedge clk_sys) begin
      if (srst) begin
         packWord <= 32'h00000000;
      end else if (start) begin
         packWord <= 32'h00000000;
      end else if (capture) begin
         case (width)
            `EMRF_WID32: packWord <= memData; // R12
            `EMRF_WID16: begin
               // First half is the upper word
               if (beat == 2'h0) packWord[31:16] <= memData[15:0]; // R14
               else packWord[15:0] <= memData[15:0]; // R14
            end
            default: begin
               case (beat)
                  2'h0: packWord[31:24] <= memData[7:0]; // R16
                  2'h1: packWord[23:16] <= memData[7:0]; // R16
                  2'h2: packWord[15:8]  <= memData[7:0]; // R16
                  default: packWord[7:0] <= memData[7:0]; // R16
               endcase
            end
         endcase
      end
   end
endmodule

// ### emrf_top.v
// Overview of operation
// R1: Refresh commands only when refresh enable bit is one.
// R2: Enabled counter loads from period, decrements each memory clock.
// R3: At zero the counter reloads from current period.
// R4: Expiry with SDRAM idle issues one auto refresh to all chips.
// R5: Expiry during access is pended; third pending forces urgent refresh.
// R6: Period field bits 11:0, read/write, resets to 128.
// R7: Counter register read-only, shows live count, 128 after reset.
// R8: Upper four bits of period and counter read zero.
// R9: Any write to init register starts SDRAM initialization.
// R10: Software writes init after chip-select setup, before SDRAM access.
// R11: Fetch reads 32 bits from 32, 16 or 8 wide memory.
// R12: 32-bit memory: one access, all byte enables low.
// R13: 16-bit memory: two transfers, address plus one, upper enables high.
// R14: 16-bit fetch: first half bits 31:16, second 15:0.
// R15: 8-bit memory: four byte transfers on low lines, address increments.
// R16: 8-bit fetch fills bytes most significant first.
// R17: 8-bit transfers drive only lowest byte enable low.
// R18: 32-bit CPU data travels as two 16-bit halves.
// R19: 32-bit writes allowed to 32/16 wide, not 8 wide.
// R20: Pending refresh count clears whenever refreshes service it.
`include "emrf_consts.vh"
module emrf_top (
   // Clock and reset
   input  wire        clk_sys,
   input  wire        srst,
   // APB slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // Requester side
   input  wire        reqValid,
   input  wire        reqWrite,
   input  wire        reqFetch,
   input  wire [21:0] reqAddr,
   input  wire [15:0] reqWrHi,
   input  wire [15:0] reqWrLo,
   output reg         reqDone,
   output reg         reqError,
   output reg  [31:0] fetchData,
   output reg  [15:0] rdHi,
   output reg  [15:0] rdLo,
   // Memory side
   input  wire        sdramBusy,
   input  wire [31:0] memRdData,
   output reg  [21:0] memAddr,
   output reg  [31:0] memWrData,
   output reg  [3:0]  byte_enable_n,
   output reg         memStrobe,
   output reg         memWrite,
   output reg         auto_refresh_command,
   output reg         urgentRefresh,
   output reg         sdramInitStart
);
   localparam ST_IDLE = 2'h0;
   localparam ST_XFER = 2'h1;
   localparam ST_CAPT = 2'h2;
   localparam ST_DONE = 2'h3;

   reg [2:0]  ctrl;
   reg [11:0] period;
   reg [1:0]  state;
   reg [1:0]  beat;
   reg [1:0]  width;
   reg        isWrite;
   reg        isFetch;
   reg [15:0] wrHi;
   reg [15:0] wrLo;
   reg [21:0] baseAddr;
   reg        pckStart;
   reg        pckCapt;
   reg [1:0]  captBeat;
   reg [31:0] next_prdata;
   wire [11:0] counter;
   wire [1:0]  pendingCount;
   wire        refCmd;
   wire        refUrgent;
   wire [31:0] packWord;

   wire refreshEnable = ctrl[`EMRF_CTRL_REF_ON];
   wire [1:0] memWidth = ctrl[`EMRF_CTRL_WID_HI:`EMRF_CTRL_WID_LO];
   wire apbAccess = psel && penable && !pready;
   wire apbWr = apbAccess && pwrite;
   // Register selects, shared by the write path and the read mux
   wire selCtrl    = (paddr == `EMRF_OFF_CTRL);
   wire selPeriod  = (paddr == `EMRF_OFF_PERIOD);
   wire selCounter = (paddr == `EMRF_OFF_COUNTER);
   wire selInit    = (paddr == `EMRF_OFF_INIT);
   wire selStatus  = (paddr == `EMRF_OFF_STATUS);
   wire selHit     = selCtrl || selPeriod || selCounter || selInit ||
                     selStatus;

   // Last beat index per width
   function [1:0] last_beat;
      input [1:0] w;
      begin
         case (w)
            `EMRF_WID32: last_beat = 2'h0;
            `EMRF_WID16: last_beat = 2'h1;
            default:     last_beat = 2'h3;
         endcase
      end
   endfunction

   // Byte enables per width, active low
   function [3:0] lanes_for;
      input [1:0] w;
      begin
         case (w)
            `EMRF_WID32: lanes_for = 4'h0; // R12
            `EMRF_WID16: lanes_for = 4'hc; // R13
            default:     lanes_for = 4'he; // R17
         endcase
      end
   endfunction

   // Codes 2 and 3 both select byte-wide memory
   function is_byte;
      input [1:0] w;
      begin
         is_byte = (w == `EMRF_WID8) || (w == 2'h3);
      end
   endfunction

   // Narrow fields read with all upper bits zero
   function [31:0] field3;
      input [2:0] v;
      begin
         field3 = {29'h0, v};
      end
   endfunction

   function [31:0] field12;
      input [11:0] v;
      begin
         field12 = {20'h00000, v}; // R8
      end
   endfunction

   // Write lanes: full bus on wide memory, upper half first otherwise
   function [31:0] wr_lanes;
      input [1:0]  w;
      input [1:0]  b;
      input [15:0] hi;
      input [15:0] lo;
      begin
         if (w == `EMRF_WID32) begin
            wr_lanes = {hi, lo};
         end else if (b == 2'h0) begin
            wr_lanes = {16'h0000, hi}; // R18
         end else begin
            wr_lanes = {16'h0000, lo}; // R18
         end
      end
   endfunction

   emrf_refresh u_refresh (
      .clk_sys       (clk_sys),
      .srst          (srst),
      .refreshEnable (refreshEnable),
      .period        (period),
      .sdramBusy     (sdramBusy),
      .counter       (counter),
      .pendingCount  (pendingCount),
      .refreshCmd    (refCmd),
      .urgent        (refUrgent)
   );

   emrf_packer u_packer (
      .clk_sys (clk_sys),
      .srst    (srst),
      .start   (pckStart),
      .width   (width),
      .beat    (captBeat),
      .memData (memRdData),
      .capture (pckCapt),
      .packWord (packWord)
   );

   // APB: one wait state, answer in the cycle after access starts
   always @(posedge clk_sys) begin
      if (srst) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= apbAccess;
         pslverr <= apbAccess && !selHit;
         if (apbAccess) begin
            prdata <= next_prdata;
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Read mux; write-only and unmapped offsets read as zero
   always @* begin
      next_prdata = 32'h00000000;
      if (selCtrl) begin
         next_prdata = field3(ctrl);
      end else if (selPeriod) begin
         next_prdata = field12(period); // R6
      end else if (selCounter) begin
         next_prdata = field12(counter); // R7
      end else if (selStatus) begin
         next_prdata = field3({pendingCount, (state != ST_IDLE)});
      end
   end

   // Writes land on the first access edge, before pready is seen
   always @(posedge clk_sys) begin
      if (srst) begin
         ctrl           <= `EMRF_CTRL_RST;
         period         <= `EMRF_PERIOD_RST; // R6
         sdramInitStart <= 1'b0;
      end else begin
         sdramInitStart <= 1'b0;
         if (apbWr && selCtrl) begin
            ctrl <= pwdata[2:0];
         end
         if (apbWr && selPeriod) begin
            period <= pwdata[11:0]; // R6
         end
         if (apbWr && selInit) begin
            // Data is ignored; any value starts the sequence
            sdramInitStart <= 1'b1; // R9
         end
      end
   end

   // Refresh outputs registered
   always @(posedge clk_sys) begin
      if (srst) begin
         auto_refresh_command <= 1'b0;
         urgentRefresh        <= 1'b0;
      end else begin
         auto_refresh_command <= refCmd; // R4
         urgentRefresh        <= refUrgent; // R5
      end
   end

   // Access sequencer: strobe, then capture, per beat
   always @(posedge clk_sys) begin
      if (srst) begin
         state         <= ST_IDLE;
         beat          <= 2'h0;
         width         <= `EMRF_WID32;
         isWrite       <= 1'b0;
         isFetch       <= 1'b0;
         wrHi          <= 16'h0000;
         wrLo          <= 16'h0000;
         baseAddr      <= 22'h000000;
         memAddr       <= 22'h000000;
         memWrData     <= 32'h00000000;
         byte_enable_n <= 4'hf;
         memStrobe     <= 1'b0;
         memWrite      <= 1'b0;
         reqDone       <= 1'b0;
         reqError      <= 1'b0;
         fetchData     <= 32'h00000000;
         rdHi          <= 16'h0000;
         rdLo          <= 16'h0000;
         pckStart      <= 1'b0;
         pckCapt       <= 1'b0;
         captBeat      <= 2'h0;
      end else begin
         reqDone  <= 1'b0;
         reqError <= 1'b0;
         pckStart <= 1'b0;
         pckCapt  <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (reqValid) begin
                  if (reqWrite && is_byte(memWidth)) begin
                     reqError <= 1'b1; // R19
                     reqDone  <= 1'b1;
                  end else begin
                     width    <= memWidth; // R11
                     isWrite  <= reqWrite && !reqFetch;
                     isFetch  <= reqFetch;
                     wrHi     <= reqWrHi; // R18
                     wrLo     <= reqWrLo; // R18
                     baseAddr <= reqAddr;
                     beat     <= 2'h0;
                     pckStart <= 1'b1;
                     state    <= ST_XFER;
                  end
               end
            end
            ST_XFER: begin
               // Each later beat steps the address by one
               memAddr       <= baseAddr + {20'h0, beat}; // R13 R15
               byte_enable_n <= lanes_for(width); // R12 R13 R17
               memStrobe     <= 1'b1;
               memWrite      <= isWrite;
               memWrData     <= wr_lanes(width, beat, wrHi, wrLo); // R18
               state <= ST_CAPT;
            end
            ST_CAPT: begin
               memStrobe     <= 1'b0;
               memWrite      <= 1'b0;
               byte_enable_n <= 4'hf;
               pckCapt       <= !isWrite;
               // Beat steps on here, so the packer gets the one captured
               captBeat      <= beat; // R14 R16
               if (beat == last_beat(width)) begin
                  state <= ST_DONE;
               end else begin
                  beat  <= beat + 2'h1;
                  state <= ST_XFER;
               end
            end
            ST_DONE: begin
               // Packer result lands one cycle after the last capture
               if (!pckCapt) begin
                  if (isFetch) begin
                     fetchData <= packWord; // R11
                  end else begin
                     rdHi <= packWord[31:16]; // R18
                     rdLo <= packWord[15:0]; // R18
                  end
                  reqDone <= 1'b1;
                  state   <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
endmodule

// ### emrf_properties.sv
module emrf_props (
   // Clock and reset
   input logic        clk_sys,
   input logic        srst,
   // APB
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic        pready,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   // Requester and memory
   input logic        reqWrite,
   input logic        reqDone,
   input logic        reqError,
   input logic        memStrobe,
   input logic        memWrite,
   input logic [21:0] memAddr,
   input logic [3:0]  byte_enable_n,
   // Refresh and init
   input logic        auto_refresh_command,
   input logic        urgentRefresh,
   input logic        sdramInitStart
);
   timeunit 1ns;
   timeprecision 1ps;
   logic enSeen;
   wire  apbWr = psel && penable && pready && pwrite;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   // Refresh pipeline may still deliver a few cycles after disable
   always @(posedge clk_sys) begin
      if (srst) begin
         enSeen <= 1'h0;
      end else if (apbWr && paddr == 12'h000) begin
         enSeen <= pwdata[0];
      end
   end
   sequence s_beat;
      memStrobe && byte_enable_n != 4'h0;
   endsequence
   sequence s_two;
      s_beat ##2 memStrobe;
   endsequence
   rfsh_needs_en_a: assert property (
      auto_refresh_command |-> enSeen || $past(enSeen, 3))
      else $error("refresh while disabled");
   rfsh_single_a: assert property (
      auto_refresh_command |=> !auto_refresh_command)
      else $error("refresh longer than one cycle");
   urgent_rfsh_a: assert property (
      urgentRefresh |-> auto_refresh_command)
      else $error("urgent without refresh");
   be_legal_a: assert property (
      memStrobe |-> byte_enable_n inside {4'h0, 4'hc, 4'he})
      else $error("bad byte enables");
   beat_addr_a: assert property (
      s_two |-> memAddr == $past(memAddr, 2) + 22'h1)
      else $error("beat address not incremented");
   one_beat_a: assert property (
      memStrobe && byte_enable_n == 4'h0 |=> !memStrobe [*2])
      else $error("extra beat on wide memory");
   no_wr8_a: assert property (
      memStrobe && byte_enable_n == 4'he |-> !memWrite)
      else $error("write to byte memory");
   wr8_refused_a: assert property (
      reqError |-> reqDone && reqWrite)
      else $error("error without refused write");
   init_start_a: assert property (
      apbWr && paddr == 12'h00c |-> ##[0:3] sdramInitStart)
      else $error("init write ignored");
endmodule

bind emrf_top emrf_props u_props (.clk_sys, .srst, .psel, .penable,
   .pwrite, .pready, .paddr, .pwdata, .reqWrite, .reqDone, .reqError,
   .memStrobe, .memWrite, .memAddr, .byte_enable_n, .auto_refresh_command,
   .urgentRefresh, .sdramInitStart);

// ### emrf_mem_model.sv
module emrf_mem_model (
   // Clock
   input  logic        clk_sys,
   // Memory side
   input  logic        memStrobe,
   input  logic [21:0] memAddr,
   output logic [31:0] memRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   initial memRdData = 32'h0;
   // Bus toggles between beats so a stale capture never matches
   always @(posedge clk_sys) begin
      if (memStrobe) begin
         memRdData <= {~memAddr[7:0], memAddr[7:0] ^ 8'h5a,
                       memAddr[15:8], memAddr[7:0]};
      end else begin
         memRdData <= ~memRdData;
      end
   end
endmodule

// ### emrf_tb.sv
`include "emrf_consts.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
   $display("unexpected t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [11:0] CTRL = `EMRF_OFF_CTRL, PER = `EMRF_OFF_PERIOD,
      CNT = `EMRF_OFF_COUNTER, INI = `EMRF_OFF_INIT, STA = `EMRF_OFF_STATUS;
   logic        clk_sys = 1'h0, srst = 1'h1, psel = 1'h0, penable = 1'h0;
   logic        pwrite = 1'h0, reqValid = 1'h0, reqWrite = 1'h0;
   logic        reqFetch = 1'h0, sdramBusy = 1'h0, err;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, rd, acc, dx, w0;
   logic [21:0] reqAddr = 22'h0, a0;
   logic [15:0] reqWrHi = 16'h0, reqWrLo = 16'h0;
   logic [1:0]  wid = 2'h0;
   logic [3:0]  seenLanes;
   wire  [31:0] prdata, fetchData, memRdData, memWrData;
   wire  [15:0] rdHi, rdLo;
   wire  [21:0] memAddr;
   wire  [3:0]  byte_enable_n;
   wire         pready, pslverr, reqDone, reqError, memStrobe, memWrite;
   wire         auto_refresh_command, urgentRefresh, sdramInitStart;
   int          failures = 0, n_checks = 0, nStb = 0, nRef = 0, nInit = 0;
   int          n;

   emrf_top DUT (.clk_sys, .srst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .reqValid, .reqWrite, .reqFetch,
      .reqAddr, .reqWrHi, .reqWrLo, .reqDone, .reqError, .fetchData, .rdHi,
      .rdLo, .sdramBusy, .memRdData, .memAddr, .memWrData, .byte_enable_n,
      .memStrobe, .memWrite, .auto_refresh_command, .urgentRefresh,
      .sdramInitStart);
   emrf_mem_model MEM (.clk_sys, .memStrobe, .memAddr, .memRdData);

   always #12.5 clk_sys = ~clk_sys;

   // Expected fetch word is packed here from the beats seen on the pins
   always @(posedge clk_sys) begin
      if (auto_refresh_command === 1'h1) nRef++;
      if (sdramInitStart === 1'h1) nInit++;
      if (memStrobe === 1'h1) begin
         if (nStb == 0) begin
            a0 = memAddr;
            w0 = memWrData;
         end
         seenLanes = byte_enable_n;
         dx = {~memAddr[7:0], memAddr[7:0] ^ 8'h5a,
               memAddr[15:8], memAddr[7:0]};
         acc = wid == 2'h0 ? dx : wid == 2'h1 ?
               {acc[15:0], dx[15:0]} : {acc[23:0], dx[7:0]};
         nStb++;
      end
   end

   task wrap_up;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task tick(input int k); repeat (k) @(posedge clk_sys); endtask
   task hang; begin failures++; wrap_up(); end endtask

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      i = 0;
      do begin @(posedge clk_sys); i++; end
      while (pready !== 1'h1 && i < 20);
      if (i >= 20) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d); apb(1'h1, a, d);
   endtask
   task rr(input logic [11:0] a); apb(1'h0, a, 32'h0); endtask

   // Valid is only looked at when idle, so it drops after the take edge
   task req(input logic w, input logic f, input logic [21:0] a);
      int i;
      nStb = 0;
      reqValid <= 1'h1;
      reqWrite <= w;
      reqFetch <= f;
      reqAddr <= a;
      @(posedge clk_sys);
      reqValid <= 1'h0;
      i = 0;
      do begin @(posedge clk_sys); i++; end
      while (reqDone !== 1'h1 && i < 40);
      if (i >= 40) hang();
      err = reqError;
      @(posedge clk_sys);
   endtask
   task gap; begin
      n = 0;
      do begin @(posedge clk_sys); n++; end
      while (auto_refresh_command !== 1'h1 && n < 200);
      if (n >= 200) hang();
   end endtask

   task t_regs;
      rr(PER); `CHK(rd, {20'h0, `EMRF_PERIOD_RST})
      rr(CNT); `CHK(rd, {20'h0, `EMRF_PERIOD_RST})
      wr(PER, 32'hffff_f123); rr(PER); `CHK(rd, 32'h123)
      wr(CNT, 32'h0); rr(CNT); `CHK(rd, 32'h123)
      rr(12'h014); `CHK({err, rd}, 33'h1_0000_0000)
      wr(INI, 32'h5a5a); tick(4); `CHK(nInit, 1)
      $display("test regs done");
   endtask
   task t_fetch;
      for (int w = 0; w < 3; w++) begin
         wid = w[1:0];
         wr(CTRL, {29'h0, wid, 1'h0});
         req(1'h0, 1'h1, 22'h000104);
         `CHK(fetchData, acc)
         `CHK(nStb, 1 << w)
         `CHK(seenLanes, w == 0 ? 4'h0 : w == 1 ? 4'hc : 4'he)
         if (w > 0) `CHK(a0, 22'h000104)
      end
      req(1'h0, 1'h0, 22'h000031); `CHK({rdHi, rdLo}, acc)
      wid = 2'h1;
      reqWrHi <= 16'hbeef;
      wr(CTRL, 32'h2); req(1'h1, 1'h0, 22'h000200);
      `CHK({err, w0[15:0]}, 17'h0_beef)
      req(1'h0, 1'h0, 22'h000207); `CHK({rdHi, rdLo}, acc)
      wr(CTRL, 32'h4); req(1'h1, 1'h0, 22'h000200);
      `CHK(err, 1'h1)
      `CHK(nStb, 0)
      $display("test fetch done");
   endtask
   task t_refresh;
      wr(PER, 32'h5); wr(CTRL, 32'h1);
      gap(); gap(); `CHK(n, 6)
      gap(); `CHK(n, 6)
      rr(CNT); `CHK(rd < 32'h6, 1'h1)
      wr(CTRL, 32'h0); tick(5);
      nRef = 0;
      tick(30); `CHK(nRef, 0)
      $display("test refresh done");
   endtask
   task t_urgent;
      wr(PER, 32'h14);
      sdramBusy <= 1'h1;
      wr(CTRL, 32'h1);
      nRef = 0;
      n = 0;
      do begin @(posedge clk_sys); n++; end
      while (urgentRefresh !== 1'h1 && n < 150);
      if (n >= 150) hang();
      tick(1); `CHK(nRef, 1)
      rr(STA); `CHK(rd[2:1], 2'h0)
      tick(22); rr(STA); `CHK(rd[2:1], 2'h1)
      sdramBusy <= 1'h0;
      nRef = 0;
      tick(6); `CHK(nRef, 1)
      rr(STA); `CHK(rd[2:1], 2'h0)
      wr(CTRL, 32'h0);
      $display("test urgent done");
   endtask

   initial begin
      tick(4);
      srst <= 1'h0;
      tick(1);
      t_regs();
      t_fetch();
      t_refresh();
      t_urgent();
      wrap_up();
   end
endmodule
